// [hw/psfc_pkg.sv]
// Shared constants and types for the predriver serial and fault control.
package psfc_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int CHANNELS   = 6;      // Gate channels
    localparam int FRAME_BITS = 8;      // Bits per device per frame
    localparam int WORD_OV    = 7;      // Over-voltage flag (word bit 8)
    localparam int WORD_UV    = 6;      // Under-voltage flag (word bit 7)

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 50;      // 20 MHz system clock
    localparam int SHORT_DEGLITCH_NS = 20000;   // Short deglitch time
    localparam int PWM_PERIOD_NS     = 100000;  // Short-fault PWM period
    localparam int PWM_ON_NS         = 5000;    // Short-fault PWM on time
    // Least time: round up
    localparam int SHORT_DEGLITCH_CYCLES =
        (SHORT_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Period and on time: round down
    localparam int PWM_PERIOD_CYCLES = PWM_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PWM_ON_CYCLES     = PWM_ON_NS / CLK_PERIOD_NS;
    // Edges after reset release until the strap synchroniser is full
    localparam int STRAP_SETTLE_CYCLES = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0] GATE_RESET = 6'h00;  // All gates off
    localparam logic [7:0] WORD_RESET = 8'h00;  // No fault
    localparam logic       CS_IDLE    = 1'h1;   // Chip select idle level

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FRAME_IDLE   = 2'b01,                   // Chip select high
        FRAME_ACTIVE = 2'b10                    // Chip select low
    } psfc_frame_type;

    typedef enum logic [1:0] {
        VAR_LATCH_UV,                           // Latch-off, with UV
        VAR_PWM_UV,                             // PWM on short, with UV
        VAR_LATCH_NOUV                          // Latch-off, no UV
    } psfc_variant_type;

    typedef logic [8:0]  psfc_dgl_type;         // Deglitch counter
    typedef logic [11:0] psfc_pwm_type;         // PWM counter

    typedef struct packed {
        psfc_frame_type   frame;                // Frame state
        logic             csSync1;              // Chip select stage 1
        logic             csSync2;              // Chip select stage 2
        logic [5:0]       parSync1;             // Parallel inputs stage 1
        logic [5:0]       parSync2;             // Parallel inputs stage 2
        logic [5:0]       drnIntSync1;          // Internal-ref compare 1
        logic [5:0]       drnIntSync2;          // Internal-ref compare 2
        logic [5:0]       drnExtSync1;          // External-ref compare 1
        logic [5:0]       drnExtSync2;          // External-ref compare 2
        logic [1:0]       batSync1;             // {over, under} stage 1
        logic [1:0]       batSync2;             // {over, under} stage 2
        logic             strapSync1;           // Reference strap stage 1
        logic             strapSync2;           // Reference strap stage 2
        logic             strapTaken;           // Strap captured
        logic             strapReg;             // Captured strap
        logic [5:0]       gateCmd;              // Latched serial command
        logic [5:0]       gateOut;              // Gate drive
        logic [5:0][8:0]  dglCnt;               // Per-channel deglitch
        logic [5:0]       shortFlag;            // Short-circuit flags
        logic [5:0]       openFlag;             // Open-load flags
        logic             ovFlag;               // Over-voltage flag
        logic             uvFlag;               // Under-voltage flag
        logic [7:0]       snapshot;             // Word captured at frame
        logic             sdoEn;                // Serial output enable
        logic             fltOe;                // Fault flag pull-down
        psfc_pwm_type     pwmCnt;               // PWM phase counter
    } psfc_sys_type;

    typedef struct packed {
        logic [7:0]       shiftReg;             // Serial shift register
    } psfc_link_type;

endpackage

// [hw/psfc_core.sv]
// Serial control, fault capture and gate drive of the six-channel predriver.
`timescale 1ns/100ps
`default_nettype none

module psfc_core
    import psfc_pkg::*;
#(
    parameter psfc_variant_type VARIANT = VAR_LATCH_UV  // Device variant
)(
    input  wire logic       clk_sys,          // System clock, 20 MHz
    input  wire logic       arst_n,           // Async reset, active low
    input  wire logic       serialClk,        // Link clock from host
    input  wire logic       chipSelect_n,     // Frame select, active low
    input  wire logic       serialIn,         // Serial data in
    output      logic       serialOut,        // Serial data out
    output      logic       serialOutEn,      // Serial output driven
    input  wire logic [5:0] parallelIn,       // Parallel channel inputs
    input  wire logic [5:0] drainAboveInt,    // Drain above internal ref
    input  wire logic [5:0] drainAboveExt,    // Drain above external ref
    input  wire logic       extRefSelect,     // Strap: 1 = external ref
    input  wire logic       batteryOver,      // Battery over-voltage
    input  wire logic       batteryUnder,     // Battery under-voltage
    output      logic [5:0] gateOut,          // Gate drive per channel
    output      logic       faultFlagOut,     // Fault flag level
    output      logic       faultFlagOe       // Fault flag pull-down
);

    // ------------------------------------------------------------
    // Variant decode
    // ------------------------------------------------------------
    localparam logic UV_ON  = (VARIANT != VAR_LATCH_NOUV);
    localparam logic PWM_ON = (VARIANT == VAR_PWM_UV);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    psfc_sys_type  sysReg;                  // System-domain state
    psfc_sys_type  sysNext;                 // Its next value
    psfc_link_type linkReg;                 // Link-domain state
    psfc_link_type linkNext;                // Its next value
    logic          started;                 // First bit of frame taken
    logic          frameOpen_n;             // Clears start flag
    logic          battery;                 // Any battery fault
    logic [5:0]    drainHigh;               // Selected comparator
    logic [5:0]    gateRaw;                 // Serial OR parallel command
    logic [5:0]    shortNow;                // Short seen this cycle
    logic [7:0]    wordNow;                 // Fault word from flags
    logic          pwmPhase;                // PWM on phase

    // ------------------------------------------------------------
    // Link domain: frame start flag
    // ------------------------------------------------------------
    // The serial clock stops between frames, so the start flag is
    // cleared by chip select itself rather than by a clock edge.
    assign frameOpen_n = arst_n & ~chipSelect_n;

    always_ff @(posedge serialClk or negedge frameOpen_n)
    begin
        if (!frameOpen_n)
            started <= 1'b0;                // Idle between frames
        else
            started <= 1'b1;                // Past the first bit
    end

    // ------------------------------------------------------------
    // Link domain: shift register
    // ------------------------------------------------------------
    // The snapshot is stable from the CS fall to the next CS fall,
    // so it is read here as a quasi-static word.
    always_comb
    begin
        linkNext = linkReg;
        if (!started)
            linkNext.shiftReg = {sysReg.snapshot[6:0], serialIn};
        else
            linkNext.shiftReg = {linkReg.shiftReg[6:0], serialIn};
    end

    // Sample on rising serial clock only while selected
    always_ff @(posedge serialClk or negedge arst_n)
    begin
        if (!arst_n)
            linkReg <= '0;
        else if (!chipSelect_n)
            linkReg <= linkNext;
    end

    // Before the first edge the word's top bit is shown directly
    assign serialOut = started ? linkReg.shiftReg[7]
                               : sysReg.snapshot[7];

    // ------------------------------------------------------------
    // System domain: decode helpers
    // ------------------------------------------------------------
    always_comb
    begin
        drainHigh = sysReg.strapReg ? sysReg.drnExtSync2
                                    : sysReg.drnIntSync2;
        battery   = sysReg.batSync2[1] | (UV_ON & sysReg.batSync2[0]);
        gateRaw   = sysReg.gateCmd | sysReg.parSync2;
        shortNow  = sysReg.gateOut & drainHigh;
        pwmPhase  = (sysReg.pwmCnt < psfc_pwm_type'(PWM_ON_CYCLES));
        wordNow   = {sysReg.ovFlag, sysReg.uvFlag,
                     sysReg.shortFlag | sysReg.openFlag};
    end

    // ------------------------------------------------------------
    // System domain: next state
    // ------------------------------------------------------------
    always_comb
    begin
        sysNext = sysReg;

        // Two-stage synchronisers for chip select, parallel, drain, battery and strap pins
        sysNext.csSync1     = chipSelect_n;
        sysNext.csSync2     = sysReg.csSync1;
        sysNext.parSync1    = parallelIn;
        sysNext.parSync2    = sysReg.parSync1;
        sysNext.drnIntSync1 = drainAboveInt;
        sysNext.drnIntSync2 = sysReg.drnIntSync1;
        sysNext.drnExtSync1 = drainAboveExt;
        sysNext.drnExtSync2 = sysReg.drnExtSync1;
        sysNext.batSync1    = {batteryOver, batteryUnder};
        sysNext.batSync2    = sysReg.batSync1;
        sysNext.strapSync1  = extRefSelect;
        sysNext.strapSync2  = sysReg.strapSync1;

        // Strap is caught once, after the synchroniser has filled.
        // Both stages reset to zero and agree at once, so an earlier
        // grab would always pick the internal reference.
        if (!sysReg.strapTaken)
        begin
            sysNext.strapReg   = sysReg.strapSync2;
            sysNext.strapTaken = (sysReg.pwmCnt
                                  == psfc_pwm_type'(STRAP_SETTLE_CYCLES));
        end

        // Free-running PWM phase
        if (sysReg.pwmCnt == psfc_pwm_type'(PWM_PERIOD_CYCLES - 1))
            sysNext.pwmCnt = '0;
        else
            sysNext.pwmCnt = sysReg.pwmCnt + 12'h001;

        // Battery flags track the detectors
        sysNext.ovFlag = sysReg.batSync2[1];
        sysNext.uvFlag = UV_ON & sysReg.batSync2[0];

        // Per-channel load fault detection
        for (int i = 0; i < CHANNELS; i++)
        begin
            // Deglitch: count continuous short, reset on any gap
            if (shortNow[i] && !battery)
            begin
                if (sysReg.dglCnt[i] != 9'(SHORT_DEGLITCH_CYCLES))
                    sysNext.dglCnt[i] = sysReg.dglCnt[i] + 9'h001;
            end
            else
                sysNext.dglCnt[i] = '0;

            // Open load follows the off-state compare
            sysNext.openFlag[i] = ~sysReg.gateOut[i] & ~drainHigh[i]
                                  & ~battery;

            // Short clears on the frame end re-arm; a new short wins
            if (sysReg.frame == FRAME_ACTIVE && sysReg.csSync2)
                sysNext.shortFlag[i] = 1'b0;
            if (PWM_ON && sysReg.gateOut[i] && !drainHigh[i])
                sysNext.shortFlag[i] = 1'b0;
            if (sysReg.dglCnt[i] == 9'(SHORT_DEGLITCH_CYCLES - 1)
                && shortNow[i])
                sysNext.shortFlag[i] = 1'b1;
            if (battery)
                sysNext.shortFlag[i] = 1'b0;

            // Gate drive per variant
            if (battery)
                sysNext.gateOut[i] = 1'b0;
            else if (sysReg.shortFlag[i] && !PWM_ON)
                sysNext.gateOut[i] = 1'b0;
            else if (sysReg.shortFlag[i])
                sysNext.gateOut[i] = gateRaw[i] & pwmPhase;
            else
                sysNext.gateOut[i] = gateRaw[i];
        end

        // Frame sequencing on synchronised chip select
        unique case (sysReg.frame)
            FRAME_IDLE:
            begin
                // Falling edge: capture word, enable output
                if (!sysReg.csSync2)
                begin
                    sysNext.frame    = FRAME_ACTIVE;
                    sysNext.snapshot = wordNow;
                    sysNext.sdoEn    = 1'b1;
                end
            end
            // Snapshot untouched here, so late faults stay out
            FRAME_ACTIVE:
            begin
                // Rising edge: latch last six bits, tri-state output
                if (sysReg.csSync2)
                begin
                    sysNext.frame   = FRAME_IDLE;
                    sysNext.gateCmd = linkReg.shiftReg[5:0];
                    sysNext.sdoEn   = 1'b0;
                end
            end
        endcase

        // Open-drain flag pulls low on any reported fault
        sysNext.fltOe = |{sysNext.ovFlag, sysNext.uvFlag,
                          sysNext.shortFlag, sysNext.openFlag};
    end

    // ------------------------------------------------------------
    // System domain: registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sysReg          <= '0;
            sysReg.frame    <= FRAME_IDLE;
            sysReg.csSync1  <= CS_IDLE;
            sysReg.csSync2  <= CS_IDLE;
            sysReg.gateCmd  <= GATE_RESET;
            sysReg.gateOut  <= GATE_RESET;
            sysReg.snapshot <= WORD_RESET;
        end
        else
            sysReg <= sysNext;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign gateOut      = sysReg.gateOut;
    assign serialOutEn  = sysReg.sdoEn;
    assign faultFlagOe  = sysReg.fltOe;
    assign faultFlagOut = 1'b0;             // Open drain: only pulls low

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_frameFall;
        sysReg.frame == FRAME_IDLE && !sysReg.csSync2;
    endsequence

    sequence s_frameRise;
        sysReg.frame == FRAME_ACTIVE && sysReg.csSync2;
    endsequence

    property p_captureWord;
        @(posedge clk_sys) disable iff (!arst_n)
        s_frameFall |=> sysReg.sdoEn && sysReg.snapshot == $past(wordNow);
    endproperty
    a_captureWord: assert property (p_captureWord)
        else $error("Fault word not captured at frame start");

    property p_wordFrozen;
        @(posedge clk_sys) disable iff (!arst_n)
        sysReg.frame == FRAME_ACTIVE ##1 sysReg.frame == FRAME_ACTIVE
        |-> $stable(sysReg.snapshot);
    endproperty
    a_wordFrozen: assert property (p_wordFrozen)
        else $error("Captured word changed during frame");

    property p_frameEnd;
        @(posedge clk_sys) disable iff (!arst_n)
        s_frameRise |=> !sysReg.sdoEn
            && sysReg.gateCmd == $past(linkReg.shiftReg[5:0]);
    endproperty
    a_frameEnd: assert property (p_frameEnd)
        else $error("Frame end did not latch gates or release output");

    property p_shiftIn;
        @(posedge serialClk) disable iff (!arst_n)
        !chipSelect_n |=> linkReg.shiftReg[0] == $past(serialIn);
    endproperty
    a_shiftIn: assert property (p_shiftIn)
        else $error("Serial input not sampled");

    property p_batteryOff;
        @(posedge clk_sys) disable iff (!arst_n)
        battery |=> sysReg.gateOut == 6'h00
            && sysReg.shortFlag == 6'h00 && sysReg.openFlag == 6'h00;
    endproperty
    a_batteryOff: assert property (p_batteryOff)
        else $error("Battery fault did not disable gates");

    property p_deglitch;
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(sysReg.shortFlag[0]) |->
            $past(sysReg.dglCnt[0]) == 9'(SHORT_DEGLITCH_CYCLES - 1);
    endproperty
    a_deglitch: assert property (p_deglitch)
        else $error("Short flagged before deglitch time");

    property p_latchOff;
        @(posedge clk_sys) disable iff (!arst_n)
        !PWM_ON && sysReg.shortFlag[0] |=> !sysReg.gateOut[0];
    endproperty
    a_latchOff: assert property (p_latchOff)
        else $error("Shorted channel not turned off");

    property p_gateOr;
        @(posedge clk_sys) disable iff (!arst_n)
        !battery && sysReg.shortFlag == 6'h00
        |=> sysReg.gateOut == $past(gateRaw);
    endproperty
    a_gateOr: assert property (p_gateOr)
        else $error("Gate is not serial OR parallel");

    property p_flagLow;
        @(posedge clk_sys) disable iff (!arst_n)
        (|wordNow) |-> sysReg.fltOe;
    endproperty
    a_flagLow: assert property (p_flagLow)
        else $error("Fault flag released with fault set");

    property p_noUv;
        @(posedge clk_sys) disable iff (!arst_n)
        !UV_ON |-> !sysReg.snapshot[WORD_UV];
    endproperty
    a_noUv: assert property (p_noUv)
        else $error("UV bit set in variant without UV");

endmodule

`default_nettype wire

// [verification/psfc_host_model.sv]
// Host model that runs chip-select framed serial transfers.
`timescale 1ns/100ps
`default_nettype none
module psfc_host_model (
    output logic      serialClk,    // Link clock, still outside frames
    output logic      chipSelect_n, // Frame select, active low
    output logic      serialIn,     // Command bits to the device
    input  wire logic serialOut,    // Fault bits from the device
    input  wire logic serialOutEn   // Device drives serialOut
);
    logic lastBit;                  // Last level seen on the data line

    // --------------------------------------------------------------
    // Idle levels
    // --------------------------------------------------------------
    initial
    begin
        serialClk    = 1'b0;
        chipSelect_n = 1'b1;
        serialIn     = 1'b0;
        lastBit      = 1'b0;
    end

    // One frame of n bits, MSB first, 32 ns link clock
    task automatic frame(input int n, input logic [15:0] tx,
                         output logic [15:0] rx);
        rx = 16'h0000;
        chipSelect_n = 1'b0;
        // Room for the device to capture its word first
        #250;
        for (int i = n - 1; i >= 0; i--)
        begin
            serialIn = tx[i];
            // Undriven line: show the inverse, never a stale value
            lastBit = serialOutEn ? serialOut : ~lastBit;
            rx[i] = lastBit;
            #16 serialClk = 1'b1;
            #16 serialClk = 1'b0;
        end
        #150 chipSelect_n = 1'b1;
        serialIn = ~serialIn;
        #300;
    endtask
endmodule
`default_nettype wire

// [verification/predriver_serial_fault_ctrl_tb.sv]
// Self-checking bench for the predriver serial and fault control.
`timescale 1ns/100ps
`default_nettype none
module predriver_serial_fault_ctrl_tb
    import psfc_pkg::*;
;
    logic clk_sys, arst_n, serialClk, chipSelect_n, serialIn;
    logic serialOut, serialOutEn, extRefSelect, batteryOver;
    logic batteryUnder, faultFlagOut, faultFlagOe;
    logic [5:0]  parallelIn, gateOut, fltInt, fltExt; // Fault masks
    logic [15:0] rx;                                  // Bits read back
    int          bad_count, checks_done;
    logic [5:0]  gateNoUv;                            // No-UV variant gates
    logic        fltNoUv;                             // No-UV variant flag

    // Drain sits opposite the gate unless a fault is injected
    wire logic [5:0] drainAboveInt = ~gateOut ^ fltInt;
    wire logic [5:0] drainAboveExt = ~gateOut ^ fltExt;

    psfc_core dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .serialClk(serialClk), .chipSelect_n(chipSelect_n),
        .serialIn(serialIn), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .parallelIn(parallelIn),
        .drainAboveInt(drainAboveInt), .drainAboveExt(drainAboveExt),
        .extRefSelect(extRefSelect), .batteryOver(batteryOver),
        .batteryUnder(batteryUnder), .gateOut(gateOut),
        .faultFlagOut(faultFlagOut), .faultFlagOe(faultFlagOe));
    // Second device without under-voltage detection, same stimulus
    psfc_core #(.VARIANT(VAR_LATCH_NOUV)) dutNoUv (.clk_sys(clk_sys),
        .arst_n(arst_n), .serialClk(serialClk),
        .chipSelect_n(chipSelect_n), .serialIn(serialIn),
        .serialOut(), .serialOutEn(), .parallelIn(parallelIn),
        .drainAboveInt(drainAboveInt), .drainAboveExt(drainAboveExt),
        .extRefSelect(extRefSelect), .batteryOver(batteryOver),
        .batteryUnder(batteryUnder), .gateOut(gateNoUv),
        .faultFlagOut(), .faultFlagOe(fltNoUv));
    psfc_host_model host (.serialClk(serialClk),
        .chipSelect_n(chipSelect_n), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic rst(input logic strap);
        @(negedge clk_sys);
        arst_n = 1'b0;
        extRefSelect = strap;
        repeat (4) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask

    // Frame, then the output must be released again
    task automatic xfer(input int n, input logic [15:0] tx);
        @(negedge clk_sys);
        host.frame(n, tx, rx);
        repeat (8) @(negedge clk_sys);
        check(serialOutEn, 1'b0);
    endtask

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_serial;
        xfer(8, 16'h002A);
        check(gateOut, 6'h2A);
        check(rx, 16'h0000);
        parallelIn = 6'h11;
        repeat (6) @(negedge clk_sys);
        check(gateOut, 6'h3B);
        xfer(8, 16'h0000);
        check(gateOut, 6'h11);
        parallelIn = 6'h00;
    endtask

    task automatic t_fault;
        fltInt = 6'h05;
        fltExt = 6'h02;
        xfer(8, 16'h0000);
        xfer(8, 16'h0000);
        check(rx, 16'h0005);
        check(faultFlagOe, 1'b1);
        fltInt = 6'h00;
        xfer(8, 16'h0000);
        xfer(8, 16'h0000);
        check(rx, 16'h0000);
        check(faultFlagOe, 1'b0);
        rst(1'b1);
        xfer(8, 16'h0000);
        check(rx, 16'h0002);
        fltExt = 6'h00;
        rst(1'b0);
        check(gateOut, GATE_RESET);
    endtask

    task automatic t_battery;
        for (int b = 0; b < 2; b++)
        begin
            {batteryOver, batteryUnder} = b ? 2'b10 : 2'b01;
            parallelIn = 6'h3F;
            fltInt = 6'h08;
            repeat (10) @(negedge clk_sys);
            check(gateOut, 6'h00);
            if (b == 0)
            begin
                check(gateNoUv, 6'h3F);
                check(fltNoUv, 1'b0);
            end
            xfer(8, 16'h0000);
            check(rx, b ? 16'h0080 : 16'h0040);
            {batteryOver, batteryUnder, fltInt} = 8'h00;
            repeat (10) @(negedge clk_sys);
            check(gateOut, 6'h3F);
            parallelIn = 6'h00;
            xfer(8, 16'h0000);
        end
    endtask

    task automatic t_cascade_short;
        xfer(16, 16'hA5C3);
        check(rx[7:0], 8'hA5);
        check(gateOut, 6'h03);
        xfer(8, 16'h0001);
        fltInt = 6'h01;
        repeat (SHORT_DEGLITCH_CYCLES - 20) @(negedge clk_sys);
        check(gateOut, 6'h01);
        repeat (40) @(negedge clk_sys);
        check(gateOut, 6'h00);
        check(faultFlagOe, 1'b1);
        xfer(8, 16'h0000);
        check(rx[0], 1'b1);
        fltInt = 6'h00;
    endtask

    // --------------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------------
    initial
    begin
        {arst_n, batteryOver, batteryUnder} = 3'b000;
        {parallelIn, fltInt, fltExt} = 18'h00000;
        bad_count = 0;
        checks_done = 0;
        rst(1'b0);
        check({gateOut, serialOutEn, faultFlagOe, faultFlagOut}, 9'h000);
        t_serial;
        t_fault;
        t_battery;
        t_cascade_short;
        end_of_test;
    end

    initial
    begin
        #300000;
        bad_count++;
        end_of_test;
    end
endmodule
`default_nettype wire
